// ==== design/eepc_map.svh ====
// register offsets, field positions and timing counts of the nonvolatile page controller
//-----------------------------------------------------------------------------
//-----------------------------------------------------------------------------
`ifndef EEPC_MAP_SVH
`define EEPC_MAP_SVH
// register offsets on the register port
`define EEPC_CTRL_OFS 8'hD2
`define EEPC_STS_OFS 8'hD3
`define EEPC_MSK_OFS 8'hD4
// control register fields
`define EEPC_BUSY_BIT 0
`define EEPC_MAP_BIT 1
`define EEPC_NIB_HI 7
`define EEPC_NIB_LO 4
`define EEPC_NIB_ARM 4'h5
`define EEPC_NIB_GO 4'hA
// status / mask bits
`define EEPC_EV_DONE 0
`define EEPC_EV_ABORT 1
`define EEPC_EV_DROP 2
// geometry
`define EEPC_ADDR_W 11
`define EEPC_PAGE_W 4
`define EEPC_BYTE_W 7
`define EEPC_PAGE_BYTES 128
`define EEPC_MEM_BYTES 2048
// reset values and the read value while busy
`define EEPC_BUSY_RST 1'b0
`define EEPC_MAP_RST 1'b0
`define EEPC_READ_BLOCKED 8'hFF
// cell programming time per row
`define EEPC_CLK_PERIOD_NS 4
`define EEPC_PROG_TIME_NS 10000
`define EEPC_PROG_CYC ((`EEPC_PROG_TIME_NS) / (`EEPC_CLK_PERIOD_NS))
`endif

// ==== design/eepc_pkg.sv ====
// types of the nonvolatile page controller
package eepc_pkg;
  // row programming engine
  typedef enum logic [2:0] {
    EEPC_ST_IDLE = 3'b001,
    EEPC_ST_COPY = 3'b010,
    EEPC_ST_WAIT = 3'b100
  } eepc_state_t;
  // launch command sequence
  typedef enum logic [2:0] {
    EEPC_SEQ_IDLE = 3'b001,
    EEPC_SEQ_ARMED = 3'b010,
    EEPC_SEQ_INSTR = 3'b100
  } eepc_seq_t;
endpackage : eepc_pkg

// ==== design/eepc_ctrl.sv ====
// nonvolatile data memory controller: space mapping, column latches, row programming
`timescale 1ns/1ps
`include "eepc_map.svh"
module eepc_ctrl
  import eepc_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // external data move port from the core
  input wire logic [15:0] i_xd_addr,
  input wire logic [7:0] i_xd_wdata,
  input wire logic i_xd_wr,
  input wire logic i_xd_rd,
  input wire logic i_instr_start,
  output logic [7:0] o_xd_rdata,
  // external ram side
  output logic o_ram_wr,
  output logic o_ram_rd,
  input wire logic [7:0] i_ram_rdata,
  // status and interrupt
  output logic o_program_busy_flag,
  output logic o_irq
);
  //---------------------------------------------------------------------------
  // state and storage
  //---------------------------------------------------------------------------
  logic nvm_space_map_enable_reg, nvm_space_map_enable_next; // map bit
  eepc_state_t st_reg, st_next; // programming engine
  eepc_seq_t seq_reg, seq_next; // launch sequence
  logic [6:0] idx_reg, idx_next; // copy index
  logic [11:0] cnt_reg, cnt_next; // cell timer
  logic [11:0] busy_run_reg, busy_run_next; // busy cycles so far, bounds the row time
  logic [3:0] row_reg, row_next; // latched page
  logic page_ok_reg, page_ok_next; // page address held
  logic [127:0] mark_reg, mark_next; // per-byte written markers
  logic [2:0] sts_reg, sts_next; // sticky events
  logic [2:0] msk_reg, msk_next; // interrupt mask
  logic [7:0] reg_rdata_reg, reg_rdata_next; // register read data
  logic [7:0] xd_rdata_reg, xd_rdata_next; // move read data
  logic [7:0] latch_mem [0:`EEPC_PAGE_BYTES-1]; // column latches
  logic [7:0] cell_mem [0:`EEPC_MEM_BYTES-1]; // nonvolatile array
  logic program_busy_flag, ctrl_wr; // busy level, control register write
  logic [3:0] launch_command_nibble;
  logic load_wr; // accepted latch load
  logic [3:0] ev_set; // bit 3 is the launch, bits 2:0 feed the status
  logic cell_we, done; // row byte write, timer expired
  logic [10:0] cell_waddr, xd_nvm_addr;

  assign program_busy_flag = (st_reg != EEPC_ST_IDLE);
  assign ctrl_wr = i_reg_wr && (i_reg_addr == `EEPC_CTRL_OFS);
  assign launch_command_nibble = i_reg_wdata[`EEPC_NIB_HI:`EEPC_NIB_LO];
  assign xd_nvm_addr = i_xd_addr[10:0];
  // ram only sees moves while the space is unmapped
  assign o_ram_wr = i_xd_wr && !nvm_space_map_enable_reg;
  assign o_ram_rd = i_xd_rd && !nvm_space_map_enable_reg;
  // loads during programming are dropped: the latches feed the copy
  assign load_wr = i_xd_wr && nvm_space_map_enable_reg && !program_busy_flag &&
                   (!page_ok_reg || xd_nvm_addr[10:7] == row_reg);
  assign done = (st_reg == EEPC_ST_WAIT) && (cnt_reg == 12'h000);

  //---------------------------------------------------------------------------
  // launch sequence and control bits
  //---------------------------------------------------------------------------
  // next values of map bit and sequence
  always_comb begin
    nvm_space_map_enable_next = nvm_space_map_enable_reg;
    seq_next = seq_reg;
    ev_set = 4'h0;
    if (ctrl_wr) begin
      // every control write rewrites the map bit; busy bit ignored
      nvm_space_map_enable_next = i_reg_wdata[`EEPC_MAP_BIT];
      if (launch_command_nibble == `EEPC_NIB_ARM) begin
        seq_next = EEPC_SEQ_ARMED;
      end else if (launch_command_nibble == `EEPC_NIB_GO && seq_reg != EEPC_SEQ_IDLE) begin
        seq_next = EEPC_SEQ_IDLE;
        ev_set[3] = !program_busy_flag; // launch
        ev_set[`EEPC_EV_ABORT] = program_busy_flag;
      end else begin
        seq_next = EEPC_SEQ_IDLE;
        ev_set[`EEPC_EV_ABORT] = (seq_reg != EEPC_SEQ_IDLE);
      end
    end else if (i_instr_start) begin
      // first boundary after the arm write is tolerated, a second one aborts
      unique case (seq_reg)
        EEPC_SEQ_IDLE: seq_next = EEPC_SEQ_IDLE;
        EEPC_SEQ_ARMED: seq_next = EEPC_SEQ_INSTR;
        EEPC_SEQ_INSTR: begin
          seq_next = EEPC_SEQ_IDLE;
          ev_set[`EEPC_EV_ABORT] = 1'b1;
        end
      endcase
    end
    ev_set[`EEPC_EV_DROP] = i_xd_wr && nvm_space_map_enable_reg && !load_wr;
    ev_set[`EEPC_EV_DONE] = done;
  end

  // register map bit and sequence
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nvm_space_map_enable_reg <= `EEPC_MAP_RST;
      seq_reg <= EEPC_SEQ_IDLE;
    end else begin
      nvm_space_map_enable_reg <= nvm_space_map_enable_next;
      seq_reg <= seq_next;
    end
  end

  //---------------------------------------------------------------------------
  // programming engine and latch bookkeeping
  //---------------------------------------------------------------------------
  // markers: one per latch byte
  generate
    for (genvar b = 0; b < `EEPC_PAGE_BYTES; b++) begin : g_mark
      always_comb begin
        if (done) begin
          mark_next[b] = 1'b0;
        end else if (load_wr && xd_nvm_addr[6:0] == 7'(b)) begin
          mark_next[b] = 1'b1;
        end else begin
          mark_next[b] = mark_reg[b];
        end
      end
    end
  endgenerate

  // next engine state, page and timer
  always_comb begin
    st_next = st_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    // run length of busy, watched so a stuck engine shows up without a long delay range
    busy_run_next = program_busy_flag ? busy_run_reg + 12'h001 : 12'h000;
    row_next = row_reg;
    page_ok_next = page_ok_reg;
    cell_we = 1'b0;
    cell_waddr = {row_reg, idx_reg};
    if (load_wr) begin
      row_next = xd_nvm_addr[10:7];
      page_ok_next = 1'b1;
    end
    unique case (st_reg)
      EEPC_ST_IDLE: begin
        if (ev_set[3]) begin
          st_next = EEPC_ST_COPY;
          idx_next = 7'h00;
        end
      end
      EEPC_ST_COPY: begin
        cell_we = mark_reg[idx_reg];
        idx_next = idx_reg + 7'h01;
        if (idx_reg == 7'h7F) begin
          st_next = EEPC_ST_WAIT;
          cnt_next = 12'(`EEPC_PROG_CYC - 1);
        end
      end
      EEPC_ST_WAIT: begin
        if (done) begin
          st_next = EEPC_ST_IDLE;
          page_ok_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - 12'h001;
        end
      end
    endcase
  end

  // register engine state
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= EEPC_ST_IDLE;
      idx_reg <= 7'h00;
      cnt_reg <= 12'h000;
      busy_run_reg <= 12'h000;
      row_reg <= 4'h0;
      page_ok_reg <= 1'b0;
      mark_reg <= '0;
    end else begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      busy_run_reg <= busy_run_next;
      row_reg <= row_next;
      page_ok_reg <= page_ok_next;
      mark_reg <= mark_next;
    end
  end

  // storage arrays carry no reset: contents are data, not control
  always_ff @(posedge i_sys_clk) begin
    if (load_wr) begin
      latch_mem[xd_nvm_addr[6:0]] <= i_xd_wdata;
    end
    if (cell_we) begin
      cell_mem[cell_waddr] <= latch_mem[idx_reg];
    end
  end

  //---------------------------------------------------------------------------
  // events, register reads and move reads
  //---------------------------------------------------------------------------
  // next status, mask and read data
  always_comb begin
    sts_next = sts_reg;
    msk_next = msk_reg;
    reg_rdata_next = 8'h00;
    xd_rdata_next = xd_rdata_reg;
    if (i_reg_wr && i_reg_addr == `EEPC_STS_OFS) begin
      sts_next = sts_reg & ~i_reg_wdata[2:0];
    end
    if (i_reg_wr && i_reg_addr == `EEPC_MSK_OFS) begin
      msk_next = i_reg_wdata[2:0];
    end
    sts_next = sts_next | ev_set[2:0]; // set wins over clear
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `EEPC_CTRL_OFS: reg_rdata_next = {6'h00, nvm_space_map_enable_reg, program_busy_flag};
        `EEPC_STS_OFS: reg_rdata_next = {5'h00, sts_reg};
        `EEPC_MSK_OFS: reg_rdata_next = {5'h00, msk_reg};
        default: reg_rdata_next = 8'h00;
      endcase
    end
    if (i_xd_rd) begin
      if (!nvm_space_map_enable_reg) begin
        xd_rdata_next = i_ram_rdata;
      end else if (program_busy_flag) begin
        xd_rdata_next = `EEPC_READ_BLOCKED;
      end else begin
        xd_rdata_next = cell_mem[xd_nvm_addr];
      end
    end
  end

  // register status, mask and read data
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sts_reg <= 3'h0;
      msk_reg <= 3'h0;
      reg_rdata_reg <= 8'h00;
      xd_rdata_reg <= 8'h00;
    end else begin
      sts_reg <= sts_next;
      msk_reg <= msk_next;
      reg_rdata_reg <= reg_rdata_next;
      xd_rdata_reg <= xd_rdata_next;
    end
  end

  assign o_reg_rdata = reg_rdata_reg;
  assign o_xd_rdata = xd_rdata_reg;
  assign o_program_busy_flag = program_busy_flag;
  assign o_irq = |(sts_reg & msk_reg);

  //---------------------------------------------------------------------------
  // assertions
  //---------------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  a_launch_sets_busy: assert property (
    ctrl_wr && launch_command_nibble == 4'hA && seq_reg != EEPC_SEQ_IDLE && !program_busy_flag
    |=> program_busy_flag) else $error("valid launch did not set busy");
  a_abort_no_busy: assert property (
    (seq_reg == EEPC_SEQ_INSTR && i_instr_start && !ctrl_wr && !program_busy_flag)
    |=> !program_busy_flag ##0 seq_reg == EEPC_SEQ_IDLE) else $error("late go not aborted");
  a_busy_clears: assert property (
    program_busy_flag
    |-> busy_run_reg <= 12'(`EEPC_PAGE_BYTES + `EEPC_PROG_CYC)) else $error("busy stuck");
  a_busy_readonly: assert property (
    ctrl_wr && !program_busy_flag && launch_command_nibble != 4'hA
    |=> !program_busy_flag) else $error("software set busy");
  a_busy_read_blocked: assert property (
    i_xd_rd && nvm_space_map_enable_reg && program_busy_flag
    |=> o_xd_rdata == 8'hFF) else $error("read served while busy");
  a_map_steers: assert property (
    nvm_space_map_enable_reg |-> !o_ram_wr && !o_ram_rd) else $error("ram hit while mapped");
  a_other_page_drop: assert property (
    i_xd_wr && page_ok_reg && !program_busy_flag && xd_nvm_addr[10:7] != row_reg
    |=> $stable(row_reg) && $stable(mark_reg)) else $error("other page byte kept");
  a_marks_cleared: assert property (
    done |=> mark_reg == '0) else $error("markers not cleared");
  a_mark_set: assert property (
    load_wr |=> mark_reg[$past(xd_nvm_addr[6:0])]) else $error("marker not set");
  a_row_from_load: assert property (
    load_wr |=> row_reg == $past(xd_nvm_addr[10:7])) else $error("row not from load");

  c_launch: cover property (ev_set[3]);
  c_abort: cover property (ev_set[`EEPC_EV_ABORT]);
  c_row_done: cover property (done ##1 !program_busy_flag);
  c_mapped_read: cover property (i_xd_rd && nvm_space_map_enable_reg && !program_busy_flag);
endmodule : eepc_ctrl

// ==== verif/eepc_ram_model.sv ====
// external ram partner: answers reads with an address-derived byte
`timescale 1ns/1ps
module eepc_ram_model (
  // clock
  input wire logic i_sys_clk,
  // strobe and address from the core side
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  // read data back to the controller
  output logic [7:0] o_rdata
);
  logic [7:0] last_reg; // last byte that was driven
  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // released bus shows the inverse so a stale value never matches
  assign o_rdata = i_rd ? (i_addr[7:0] ^ 8'h5A) : ~last_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_rd) begin
      last_reg <= o_rdata;
    end
  end
endmodule : eepc_ram_model

// ==== verif/tb_top.sv ====
// self-checking bench of the nonvolatile page controller
`timescale 1ns/1ps
`include "eepc_map.svh"
module tb_top;
  import eepc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, rwr = 1'b0, rrd = 1'b0, xwr = 1'b0, xrd = 1'b0, ist = 1'b0;
  logic [7:0] ra = 8'h00, rwd = 8'h00, xwd = 8'h00, rrdata, xrdata, ramd;
  logic [15:0] xa = 16'h0000;
  logic ramwr, ramrd, busy, irq, rrd_d = 1'b0, xrd_d = 1'b0;
  logic [7:0] rq[$], xq[$], dat[0:127]; // expected reads, loaded bytes
  int n_fail = 0, tests_run = 0, offs[4] = '{0, 1, 64, 127};
  always #2 clk = ~clk; // 250 MHz
  eepc_ctrl uut (.i_sys_clk(clk), .i_rstn(rstn), .i_reg_addr(ra), .i_reg_wdata(rwd),
    .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rrdata), .i_xd_addr(xa), .i_xd_wdata(xwd),
    .i_xd_wr(xwr), .i_xd_rd(xrd), .i_instr_start(ist), .o_xd_rdata(xrdata), .o_ram_wr(ramwr),
    .o_ram_rd(ramrd), .i_ram_rdata(ramd), .o_program_busy_flag(busy), .o_irq(irq));
  eepc_ram_model ram (.i_sys_clk(clk), .i_rd(ramrd), .i_addr(xa), .o_rdata(ramd));
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // monitor: read data are checked in the cycle after the strobe; register data stand only then
  always @(posedge clk) begin
    rrd_d <= rrd;
    xrd_d <= xrd;
  end
  always @(negedge clk) begin
    if (rrd_d) check(rrdata, rq.pop_front());
    if (xrd_d) check(xrdata, xq.pop_front());
  end
  // ---------------------------------------------------------------
  // bus tasks: one-cycle strobes, changed right after the edge
  // ---------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
  endtask : reg_rd
  task automatic xd(input logic w, input logic [15:0] a, input logic [7:0] d);
    if (!w) xq.push_back(d); // a read carries its expected byte
    @(posedge clk);
    xa <= a;
    xwd <= d;
    xwr <= w;
    xrd <= !w;
    @(posedge clk);
    xwr <= 1'b0;
    xrd <= 1'b0;
  endtask : xd
  task automatic instr();
    @(posedge clk);
    ist <= 1'b1;
    @(posedge clk);
    ist <= 1'b0;
  endtask : instr
  // valid launch keeps the map bit: every write repeats bit 1 below the command nibble
  task automatic launch();
    reg_wr(`EEPC_CTRL_OFS, 8'h52);
    instr();
    reg_wr(`EEPC_CTRL_OFS, 8'hA2);
    #1 check(busy, 1'b1);
    reg_wr(`EEPC_CTRL_OFS, 8'h02);
    #1 check(busy, 1'b1);
    xd(1'b0, 16'h0180, 8'hFF);
    reg_rd(`EEPC_CTRL_OFS, 8'h03);
  endtask : launch
  // bounded wait for the row to finish, well above 128 + 2500 cycles
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    #1 check(busy, 1'b0);
    reg_rd(`EEPC_STS_OFS, 8'h01);
    reg_wr(`EEPC_STS_OFS, 8'h01);
    reg_wr(`EEPC_CTRL_OFS, 8'h02);
  endtask : wait_idle
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hEFB7));
    foreach (dat[i]) dat[i] = 8'($urandom());
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    check(busy, 1'b0);
    reg_rd(`EEPC_CTRL_OFS, 8'h00);
    reg_rd(8'h10, 8'h00);
    xd(1'b0, 16'h0123, 8'h23 ^ 8'h5A);
    // unmapped write must reach the ram side
    @(posedge clk);
    xa <= 16'h0123;
    xwr <= 1'b1;
    @(negedge clk);
    check(ramwr, 1'b1);
    @(posedge clk);
    xwr <= 1'b0;
    reg_wr(`EEPC_CTRL_OFS, 8'h03);
    reg_rd(`EEPC_CTRL_OFS, 8'h02);
    // page 3 bytes, then a stray byte on page 5 that must be dropped
    foreach (offs[i]) xd(1'b1, 16'h0180 + 16'(offs[i]), dat[offs[i]]);
    xd(1'b1, 16'h0281, 8'h33);
    reg_rd(`EEPC_STS_OFS, 8'h04);
    reg_wr(`EEPC_STS_OFS, 8'h04);
    reg_rd(`EEPC_STS_OFS, 8'h00);
    // broken unlock: two instructions between the two writes
    reg_wr(`EEPC_CTRL_OFS, 8'h50);
    instr();
    instr();
    reg_wr(`EEPC_CTRL_OFS, 8'hA0);
    #1 check(busy, 1'b0);
    reg_rd(`EEPC_STS_OFS, 8'h02);
    #1 check(irq, 1'b0); // masked event stays quiet
    reg_wr(`EEPC_MSK_OFS, 8'h07);
    @(posedge clk);
    #1 check(irq, 1'b1);
    reg_wr(`EEPC_STS_OFS, 8'h02);
    @(posedge clk);
    #1 check(irq, 1'b0);
    reg_wr(`EEPC_MSK_OFS, 8'h00);
    launch();
    wait_idle();
    foreach (offs[i]) xd(1'b0, 16'h0180 + 16'(offs[i]), dat[offs[i]]);
    // second session on one byte: old markers must be gone
    xd(1'b1, 16'h0180, ~dat[0]);
    launch();
    wait_idle();
    xd(1'b0, 16'h0180, ~dat[0]);
    xd(1'b0, 16'h01FF, dat[127]);
    repeat (3) @(posedge clk);
    finish_test();
  end
  // watchdog: the run needs about 5,350 cycles
  initial begin
    #80000;
    n_fail++;
    finish_test();
  end
endmodule : tb_top
